/* inc/bis_pkg.sv */
package bis_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int BIS_CLK_HZ = 100_000_000;
  localparam int BIS_MS_PER_S = 1000;
  localparam int BIS_CYC_PER_MS = BIS_CLK_HZ / BIS_MS_PER_S;
  localparam int BIS_FLAME_ON_MS = 1000;
  localparam int BIS_FLAME_OFF_BASE_MS = 1000;
  localparam int BIS_CNT_W = 40;
  localparam int BIS_FLAME_ON_CYC = BIS_FLAME_ON_MS * BIS_CYC_PER_MS;
  localparam int BIS_FLAME_OFF_BASE_CYC = BIS_FLAME_OFF_BASE_MS * BIS_CYC_PER_MS;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] BIS_OFF_CTRL = 8'h00;
  localparam logic [7:0] BIS_OFF_EXT = 8'h04;
  localparam logic [7:0] BIS_OFF_ACCESS = 8'h08;
  localparam logic [7:0] BIS_OFF_STATUS = 8'h0c;
  localparam logic [7:0] BIS_OFF_INTENS = 8'h10;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int BIS_CTRL_POC_LSB = 0;
  localparam int BIS_CTRL_GMAX_BIT = 2;
  localparam int BIS_CTRL_AND_BIT = 3;
  localparam int BIS_CTRL_RST_LSB = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] BIS_POC_RST = 2'h1;
  localparam logic BIS_GMAX_RST = 1'b0;
  localparam logic BIS_AND_RST = 1'b0;
  localparam logic [2:0] BIS_RESTART_RST = 3'h0;
  localparam logic [15:0] BIS_EXT_RST = 16'h0777;
  localparam logic [1:0] BIS_ACC_RST = 2'h0;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] BIS_POC_OFF = 2'h0;
  localparam logic [1:0] BIS_POC_BRIDGE = 2'h1;
  localparam logic [1:0] BIS_POC_CHANGE = 2'h2;
  localparam logic [1:0] BIS_ACC_HE = 2'h1;
  localparam logic [1:0] BIS_ACC_OEM = 2'h2;
  localparam logic [2:0] BIS_RESTART_MAX = 3'h4;
  localparam logic [7:0] BIS_INTENS_MAX = 8'h64;
  localparam logic [4:0] BIS_LOC_FLAME_OR = 5'h02;
  localparam logic [4:0] BIS_LOC_FLAME_AND = 5'h07;
  localparam logic [4:0] BIS_LOC_POC = 5'h0e;
  localparam logic [4:0] BIS_LOC_GMAX = 5'h15;

  typedef enum logic [1:0] {
    BIS_ST_RUN = 2'b01,
    BIS_ST_LOCK = 2'b10
  } bis_state_t;

endpackage

/* core/bis_sync2.sv */
`timescale 1ns/10ps
module bis_sync2 import bis_pkg::*; #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bis_sync_t;

  bis_sync_t r;
  bis_sync_t next_r;

  // first stage is read by the second stage only
  always_comb
  begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign q = r.s2;

endmodule

/* core/bis_flame_filter.sv */
`timescale 1ns/10ps
module bis_flame_filter import bis_pkg::*; #(
  parameter int CW = BIS_CNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic raw,
  input wire logic [CW-1:0] on_cycles,
  input wire logic [CW-1:0] off_cycles,
  output logic filt
);

  localparam logic [CW-1:0] ONE = CW'(1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic filt;
  } bis_filt_t;

  bis_filt_t r;
  bis_filt_t next_r;
  logic [CW-1:0] target;

  // ----------------------------------------------------------------
  // stability counter
  // ----------------------------------------------------------------
  // a glitch restarts the count, so short flicker never toggles the output
  always_comb
  begin
    next_r = r;
    target = raw ? on_cycles : off_cycles;
    if (raw == r.filt)
      next_r.cnt = '0;
    else if (r.cnt + ONE >= target)
    begin
      next_r.filt = raw;
      next_r.cnt = '0;
    end
    else
      next_r.cnt = r.cnt + ONE;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign filt = r.filt;

  flame_rise_a: assert property (@(posedge hclk) disable iff (!hresetn) $rose(filt) |-> $past(raw))
    else $error("flame output rose without flame");
  flame_fall_a: assert property (@(posedge hclk) disable iff (!hresetn) $fell(filt) |-> !$past(raw))
    else $error("flame output fell with flame present");

endmodule

/* core/bis_supervisor.sv */
// Overview of operation
// - proof contact mode zero: contact input ignored completely.
// - mode one: contact must be closed in startup and shutdown.
// - mode two: also contact must be open when entering operation.
// - wrong contact level in a checked phase locks out, code 14.
// - proof contact mode resets to one.
// - proof contact mode writable from heating engineer level.
// - one bit enables maximum gas pressure supervision.
// - maximum pressure watched only in operation from second interval on.
// - maximum pressure switch open while watched locks out, code 21.
// - maximum pressure switch ignored before second interval.
// - flame channels combined by OR at zero; at one by AND past second safety, else OR.
// - flame appearance recognised within one second, fixed.
// - zero extension: flame fault reaction within one second.
// - flame fault reaction is one second plus set extension.
// - extension resets to 1.911 seconds.
// - restart limit: settings 0,1 none; 2,3,4 give one to three.
// - ionization intensity readable as 0 to 100 percent.
// - AND mode: one flame after first safety, else 2; both after second, else 7.
// - OR mode: no flame during operation locks out, code 2.
// - extraneous light always checked by OR in startup and shutdown, until past first safety.
`timescale 1ns/10ps
module bis_supervisor import bis_pkg::*; #(
  parameter int CYC_PER_MS = BIS_CYC_PER_MS,
  parameter int FLAME_ON_CYC = BIS_FLAME_ON_CYC,
  parameter int FLAME_OFF_BASE_CYC = BIS_FLAME_OFF_BASE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic proof_contact_pin,
  input wire logic gas_max_pin,
  input wire logic ion_flame_pin,
  input wire logic optical_flame_pin,
  input wire logic [7:0] ion_intensity,
  input wire logic phase_startup,
  input wire logic phase_shutdown,
  input wire logic phase_enter_operation,
  input wire logic phase_operation,
  input wire logic second_interval,
  input wire logic past_first_safety,
  input wire logic past_second_safety,
  input wire logic cycle_start,
  input wire logic unlock_req,
  output logic lockout_req,
  output logic [4:0] lockout_code,
  output logic restart_req,
  output logic extraneous_light,
  output logic flame_ok
);

  typedef struct packed {
    logic aw_act;
    logic aw_write;
    logic [7:0] aw_addr;
    logic [31:0] hrdata;
    logic [1:0] poc_cfg;
    logic gmax_en;
    logic and_mode;
    logic [2:0] restart_cfg;
    logic [15:0] ext_ms;
    logic [1:0] acc;
    bis_state_t st;
    logic [4:0] code;
    logic [1:0] restarts;
    logic restart_req;
    logic fault_q;
    logic extraneous;
    logic flame_ok;
    logic [6:0] intensity;
    logic [BIS_CNT_W-1:0] off_cyc;
  } bis_main_t;

  bis_main_t q;
  bis_main_t n;

  // ----------------------------------------------------------------
  // input synchronisers and flame filters
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic poc_closed;
  logic gmax_closed;
  logic [1:0] flame_f;

  bis_sync2 #(.W(4)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({optical_flame_pin, ion_flame_pin, gas_max_pin, proof_contact_pin}),
    .q(pins_s)
  );

  assign poc_closed = pins_s[0];
  assign gmax_closed = pins_s[1];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_flame
      bis_flame_filter #(.CW(BIS_CNT_W)) u_filt (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(pins_s[2 + gi]),
        .on_cycles(BIS_CNT_W'(FLAME_ON_CYC)),
        .off_cycles(q.off_cyc),
        .filt(flame_f[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] bis_allowed(input logic [2:0] cfg);
    begin
      if (cfg <= 3'h1)
        bis_allowed = 2'h0;
      else if (cfg >= BIS_RESTART_MAX)
        bis_allowed = 2'h3;
      else
        bis_allowed = 2'(cfg - 3'h1);
    end
  endfunction

  function automatic logic [31:0] bis_rd(input logic [7:0] addr, input bis_main_t s, input logic [1:0] fl);
    begin
      case (addr)
        BIS_OFF_CTRL: bis_rd = {25'h0, s.restart_cfg, s.and_mode, s.gmax_en, s.poc_cfg};
        BIS_OFF_EXT: bis_rd = {16'h0, s.ext_ms};
        BIS_OFF_ACCESS: bis_rd = {30'h0, s.acc};
        BIS_OFF_STATUS: bis_rd = {20'h0, s.extraneous, fl, s.flame_ok, s.restarts, s.st == BIS_ST_LOCK, s.code};
        BIS_OFF_INTENS: bis_rd = {25'h0, s.intensity};
        default: bis_rd = 32'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // supervision terms
  // ----------------------------------------------------------------
  logic checked_phase;
  logic poc_bad;
  logic poc_chg_bad;
  logic gmax_bad;
  logic flame_any;
  logic flame_need;
  logic flame_fault;
  logic fault_rise;
  logic [4:0] fault_code;
  logic evt;
  logic [4:0] evt_code;
  logic restart_ok;

  always_comb
  begin
    checked_phase = phase_startup || phase_shutdown;
    poc_bad = (q.poc_cfg != BIS_POC_OFF) && checked_phase && !poc_closed;
    poc_chg_bad = (q.poc_cfg == BIS_POC_CHANGE) && phase_enter_operation && poc_closed;
    gmax_bad = q.gmax_en && phase_operation && second_interval && !gmax_closed;
    flame_any = flame_f[0] || flame_f[1];
    if (q.and_mode && past_second_safety)
      flame_need = flame_f[0] && flame_f[1];
    else
      flame_need = flame_any;
    flame_fault = past_first_safety && !flame_need;
    fault_rise = flame_fault && !q.fault_q;
    fault_code = (q.and_mode && past_second_safety) ? BIS_LOC_FLAME_AND : BIS_LOC_FLAME_OR;
    restart_ok = q.restarts < bis_allowed(q.restart_cfg);
    evt = 1'b0;
    evt_code = 5'h00;
    // contact faults outrank pressure, pressure outranks flame
    if (poc_bad || poc_chg_bad)
    begin
      evt = 1'b1;
      evt_code = BIS_LOC_POC;
    end
    else if (gmax_bad)
    begin
      evt = 1'b1;
      evt_code = BIS_LOC_GMAX;
    end
    else if (fault_rise && !restart_ok)
    begin
      evt = 1'b1;
      evt_code = fault_code;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = q;
    n.restart_req = 1'b0;
    n.fault_q = flame_fault;
    n.extraneous = checked_phase && !past_first_safety && flame_any;
    n.flame_ok = flame_need;
    n.intensity = (ion_intensity > BIS_INTENS_MAX) ? BIS_INTENS_MAX[6:0] : ion_intensity[6:0];
    // extension multiplied out every cycle, keeps the filter compare cheap
    n.off_cyc = BIS_CNT_W'(FLAME_OFF_BASE_CYC) + BIS_CNT_W'(q.ext_ms) * BIS_CNT_W'(CYC_PER_MS);

    // register writes in the data phase
    if (q.aw_act && q.aw_write)
    begin
      case (q.aw_addr)
        BIS_OFF_CTRL:
        begin
          if (q.acc >= BIS_ACC_HE && hwdata[BIS_CTRL_POC_LSB +: 2] <= BIS_POC_CHANGE)
            n.poc_cfg = hwdata[BIS_CTRL_POC_LSB +: 2];
          if (q.acc >= BIS_ACC_OEM)
          begin
            n.gmax_en = hwdata[BIS_CTRL_GMAX_BIT];
            n.and_mode = hwdata[BIS_CTRL_AND_BIT];
            if (hwdata[BIS_CTRL_RST_LSB +: 3] <= BIS_RESTART_MAX)
              n.restart_cfg = hwdata[BIS_CTRL_RST_LSB +: 3];
          end
        end
        BIS_OFF_EXT:
        begin
          if (q.acc >= BIS_ACC_OEM)
            n.ext_ms = hwdata[15:0];
        end
        BIS_OFF_ACCESS: n.acc = hwdata[1:0];
        default: ;
      endcase
    end

    // address phase capture, zero wait states
    n.aw_act = hsel && hready && htrans[1];
    if (hsel && hready)
    begin
      n.aw_write = hwrite;
      n.aw_addr = haddr[7:0];
    end
    if (hsel && hready && htrans[1] && !hwrite)
      n.hrdata = bis_rd(haddr[7:0], n, flame_f);

    // lockout and restart control
    case (q.st)
      BIS_ST_RUN:
      begin
        if (cycle_start)
          n.restarts = 2'h0;
        if (evt)
        begin
          n.st = BIS_ST_LOCK;
          n.code = evt_code;
        end
        else if (fault_rise)
        begin
          n.restart_req = 1'b1;
          n.restarts = 2'(q.restarts + 2'h1);
        end
      end
      BIS_ST_LOCK:
      begin
        // a fault in the unlock cycle keeps the lockout
        if (unlock_req && evt)
          n.code = evt_code;
        else if (unlock_req)
        begin
          n.st = BIS_ST_RUN;
          n.code = 5'h00;
          n.restarts = 2'h0;
        end
      end
      default:
      begin
        n.st = BIS_ST_LOCK;
        n.code = 5'h00;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.poc_cfg <= BIS_POC_RST;
      q.gmax_en <= BIS_GMAX_RST;
      q.and_mode <= BIS_AND_RST;
      q.restart_cfg <= BIS_RESTART_RST;
      q.ext_ms <= BIS_EXT_RST;
      q.acc <= BIS_ACC_RST;
      q.st <= BIS_ST_RUN;
    end
    else
      q <= n;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign lockout_req = q.st == BIS_ST_LOCK;
  assign lockout_code = q.code;
  assign restart_req = q.restart_req;
  assign extraneous_light = q.extraneous;
  assign flame_ok = q.flame_ok;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking bis_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_unlock_clean;
    lockout_req && unlock_req && !evt;
  endsequence

  sequence s_run_quiet;
    q.st == BIS_ST_RUN && !poc_bad && !poc_chg_bad;
  endsequence

  poc_off_a: assert property (s_run_quiet and (q.poc_cfg == BIS_POC_OFF && !gmax_bad && !fault_rise) |=> !lockout_req)
    else $error("lockout with proof contact disabled");
  poc_lock_a: assert property (q.st == BIS_ST_RUN && poc_bad |=> lockout_req && lockout_code == 5'h0e)
    else $error("proof contact fault did not lock with 14");
  poc_change_a: assert property (q.st == BIS_ST_RUN && q.poc_cfg == BIS_POC_CHANGE && phase_enter_operation && poc_closed
      |=> lockout_code == 5'h0e)
    else $error("closed contact at operation entry not locked");
  gmax_lock_a: assert property (s_run_quiet and gmax_bad |=> lockout_req && lockout_code == 5'h15)
    else $error("pressure fault did not lock with 21");
  gmax_early_a: assert property (s_run_quiet and (!second_interval && !fault_rise) |=> !lockout_req)
    else $error("lockout before second interval");
  lock_hold_a: assert property (lockout_req && !unlock_req |=> lockout_req && $stable(lockout_code))
    else $error("lockout code not held");
  unlock_clear_a: assert property (s_unlock_clean |=> !lockout_req ##0 lockout_code == 5'h00)
    else $error("unlock did not clear lockout");
  restart_lim_a: assert property (restart_req |-> q.restarts != 2'h0 && q.restarts <= bis_allowed(q.restart_cfg))
    else $error("restart beyond limit");
  and_lock_a: assert property (s_run_quiet and (!gmax_bad && fault_rise && !restart_ok && q.and_mode && past_second_safety)
      |=> lockout_code == 5'h07)
    else $error("and mode flame loss not coded 7");
  extra_light_a: assert property (checked_phase && !past_first_safety && flame_f[1] |=> extraneous_light)
    else $error("optical flame not flagged as extraneous light");
  poc_reset_a: assert property ($rose(hresetn) |-> q.poc_cfg == 2'h1 && q.ext_ms == 16'h0777)
    else $error("factory values wrong after reset");
  intens_a: assert property (q.intensity <= 7'h64)
    else $error("intensity above full scale");

endmodule

/* tb/bis_field_model.sv */
`timescale 1ns/10ps
module bis_field_model (
  input wire logic hclk,
  input wire logic contact_closed,
  input wire logic pressure_ok,
  input wire logic ion_on,
  input wire logic opt_on,
  input wire logic [7:0] intensity,
  output logic proof_contact_pin,
  output logic gas_max_pin,
  output logic ion_flame_pin,
  output logic optical_flame_pin,
  output logic [7:0] ion_intensity
);
  // ----------------------------------------------------------------
  // field contacts and flame detectors
  // ----------------------------------------------------------------
  // contacts move one clock after a command, never on the same edge
  initial
  begin
    {proof_contact_pin, gas_max_pin, ion_flame_pin, optical_flame_pin} = 4'hc;
    ion_intensity = 8'h00;
  end

  always @(posedge hclk)
  begin
    proof_contact_pin <= contact_closed;
    gas_max_pin <= pressure_ok;
    ion_flame_pin <= ion_on;
    optical_flame_pin <= opt_on;
    ion_intensity <= intensity;
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top import bis_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic hreadyout, hresp, lockout_req, restart_req, extraneous_light, flame_ok;
  logic [4:0] lockout_code;
  logic proof_contact_pin, gas_max_pin, ion_flame_pin, optical_flame_pin;
  logic [7:0] ion_intensity;
  logic want_contact = 1'b1, want_press = 1'b1, want_ion = 1'b0, want_opt = 1'b0;
  logic [7:0] want_int = 8'h00;
  // sequencer phase levels, changed only after a clock edge
  logic ph_start = 1'b0, ph_shut = 1'b0, ph_enter = 1'b0, ph_op = 1'b0;
  logic sec_int = 1'b0, safe1 = 1'b0, safe2 = 1'b0, cyc_start = 1'b0, unlock = 1'b0;
  int n_mismatch = 0, checks_done = 0, cyc = 0;

  always #5 hclk = ~hclk;

  bis_field_model field_u (.hclk(hclk), .contact_closed(want_contact), .pressure_ok(want_press),
    .ion_on(want_ion), .opt_on(want_opt), .intensity(want_int), .proof_contact_pin(proof_contact_pin),
    .gas_max_pin(gas_max_pin), .ion_flame_pin(ion_flame_pin), .optical_flame_pin(optical_flame_pin),
    .ion_intensity(ion_intensity));

  // short counts keep the flame filters to tens of cycles
  bis_supervisor #(.CYC_PER_MS(10), .FLAME_ON_CYC(20), .FLAME_OFF_BASE_CYC(20)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .proof_contact_pin(proof_contact_pin), .gas_max_pin(gas_max_pin),
    .ion_flame_pin(ion_flame_pin), .optical_flame_pin(optical_flame_pin), .ion_intensity(ion_intensity),
    .phase_startup(ph_start), .phase_shutdown(ph_shut), .phase_enter_operation(ph_enter),
    .phase_operation(ph_op), .second_interval(sec_int), .past_first_safety(safe1),
    .past_second_safety(safe2), .cycle_start(cyc_start), .unlock_req(unlock),
    .lockout_req(lockout_req), .lockout_code(lockout_code), .restart_req(restart_req),
    .extraneous_light(extraneous_light), .flame_ok(flame_ok));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // no cycle limit of its own: a stuck bus ends only through the bench timeout
  task automatic wait_rdy;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rv = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, rv & m, e);
  endtask

  // a level must rise no earlier than lo and no later than hi cycles from now
  task automatic wait_hi(input string nm, input int sel, input int lo, input int hi);
    int n;
    logic s;
    n = 0;
    s = 1'b0;
    while (s !== 1'b1 && n <= hi)
    begin
      @(posedge hclk);
      n++;
      case (sel)
        0: s = lockout_req;
        1: s = flame_ok;
        2: s = restart_req;
        default: s = extraneous_light;
      endcase
    end
    chk(nm, 32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic idle_chk;
    repeat (12) @(posedge hclk);
    chk("lock idle", 32'(lockout_req), 32'h0);
  endtask

  // phases dropped first so no fault is active in the unlock cycle
  task automatic calm;
    {ph_start, ph_shut, ph_op, sec_int, safe1, safe2} <= 6'h0;
    repeat (4) @(posedge hclk);
    unlock <= 1'b1;
    @(posedge hclk);
    unlock <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("unlock", 32'({lockout_req, lockout_code}), 32'h0);
  endtask

  task automatic enter_op;
    repeat (4) @(posedge hclk);
    ph_enter <= 1'b1;
    @(posedge hclk);
    ph_enter <= 1'b0;
  endtask

  task automatic flame_run(input logic [31:0] ext, input int lo, input int hi);
    wr(BIS_OFF_EXT, ext);
    want_ion <= 1'b1;
    wait_hi("flame on", 1, 20, 30);
    {ph_op, safe1} <= 2'h3;
    repeat (3) @(posedge hclk);
    want_ion <= 1'b0;
    wait_hi("flame out", 0, lo, hi);
    chk("flame code", 32'(lockout_code), 32'h02);
    calm;
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out;
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("ctrl rst", BIS_OFF_CTRL, 32'h7f, 32'h01);
    rd("ext rst", BIS_OFF_EXT, 32'hffff, 32'h0777);
    rd("access rst", BIS_OFF_ACCESS, 32'h3, 32'h0);
    rd("status rst", BIS_OFF_STATUS, 32'hfff, 32'h0);
    rd("unmapped", 8'h14, 32'hffffffff, 32'h0);
    wr(BIS_OFF_CTRL, 32'h0);
    rd("ctrl user", BIS_OFF_CTRL, 32'h7f, 32'h01);
    wr(BIS_OFF_ACCESS, 32'h1);
    wr(BIS_OFF_CTRL, 32'h0e);
    rd("ctrl engineer", BIS_OFF_CTRL, 32'h7f, 32'h02);
    wr(BIS_OFF_CTRL, 32'h0);
    want_contact <= 1'b0;
    ph_start <= 1'b1;
    idle_chk;
    wr(BIS_OFF_CTRL, 32'h1);
    wait_hi("contact start", 0, 0, 10);
    want_contact <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("code latch", 32'({lockout_req, lockout_code}), 32'h2e);
    calm;
    enter_op;
    idle_chk;
    wr(BIS_OFF_CTRL, 32'h2);
    enter_op;
    wait_hi("contact enter", 0, 0, 10);
    chk("enter code", 32'(lockout_code), 32'h0e);
    calm;
    want_contact <= 1'b0;
    enter_op;
    idle_chk;
    ph_shut <= 1'b1;
    wait_hi("contact shut", 0, 0, 10);
    calm;
    want_contact <= 1'b1;
    wr(BIS_OFF_ACCESS, 32'h2);
    wr(BIS_OFF_CTRL, 32'h4);
    rd("ctrl gas", BIS_OFF_CTRL, 32'h7f, 32'h04);
    want_press <= 1'b0;
    ph_op <= 1'b1;
    idle_chk;
    sec_int <= 1'b1;
    wait_hi("gas lock", 0, 0, 10);
    chk("gas code", 32'(lockout_code), 32'h15);
    calm;
    wr(BIS_OFF_CTRL, 32'h0);
    {ph_op, sec_int} <= 2'h3;
    idle_chk;
    want_press <= 1'b1;
    flame_run(32'h0, 20, 30);
    flame_run(32'h3, 50, 60);
    wr(BIS_OFF_EXT, 32'h0);
    wr(BIS_OFF_CTRL, 32'h8);
    {want_ion, want_opt} <= 2'h3;
    wait_hi("both on", 1, 20, 30);
    {ph_op, safe1, safe2} <= 3'h7;
    repeat (3) @(posedge hclk);
    want_opt <= 1'b0;
    wait_hi("and out", 0, 20, 30);
    chk("and code", 32'(lockout_code), 32'h07);
    calm;
    want_ion <= 1'b0;
    repeat (40) @(posedge hclk);
    {want_opt, ph_start} <= 2'h3;
    wait_hi("extraneous", 3, 20, 30);
    {want_opt, ph_start} <= 2'h0;
    wr(BIS_OFF_CTRL, 32'h20);
    repeat (40) @(posedge hclk);
    want_ion <= 1'b1;
    wait_hi("ion on", 1, 20, 30);
    {ph_op, safe1, cyc_start} <= 3'h7;
    @(posedge hclk);
    {cyc_start, want_ion} <= 2'h0;
    wait_hi("restart", 2, 20, 30);
    chk("no lock", 32'(lockout_req), 32'h0);
    rd("restarts", BIS_OFF_STATUS, 32'hc0, 32'h40);
    want_ion <= 1'b1;
    wait_hi("ion back", 1, 20, 30);
    want_ion <= 1'b0;
    wait_hi("second loss", 0, 20, 30);
    calm;
    want_int <= 8'h32;
    repeat (3) @(posedge hclk);
    rd("intensity", BIS_OFF_INTENS, 32'h7f, 32'h32);
    want_int <= 8'hc8;
    repeat (3) @(posedge hclk);
    rd("intensity top", BIS_OFF_INTENS, 32'h7f, 32'h64);
    close_out;
  end
endmodule
